// ---- rtl/codec_port_pkg.sv ----
package codec_port_pkg;

  // Register map, word addresses on the register port.
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL1    = 4'h0;
  localparam logic [3:0] ADDR_CTRL2    = 4'h1;
  localparam logic [3:0] ADDR_TX_SLOT  = 4'h2;
  localparam logic [3:0] ADDR_RX_SLOT  = 4'h3;
  localparam logic [3:0] ADDR_TX_HOLD0 = 4'h4;
  localparam logic [3:0] ADDR_RX_HOLD0 = 4'h8;
  localparam logic [3:0] ADDR_STATUS   = 4'hC;

  // Field positions.
  localparam int unsigned BIT_PORT_ENABLE = 15;
  localparam int unsigned BIT_IDLE_MODE   = 6;
  localparam int unsigned BLEN_LSB        = 10;
  localparam int unsigned FSLOTS_LSB      = 5;
  localparam int unsigned WS_LSB          = 0;
  localparam int unsigned STAT_PTR_LSB    = 0;
  localparam int unsigned STAT_SLOT_LSB   = 4;
  localparam int unsigned STAT_ACTIVE     = 8;
  localparam int unsigned STAT_STARTED    = 9;

  // Widths and limits.
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned HOLD_N   = 4;
  localparam logic [3:0]  WS_MIN   = 4'h3;
  localparam logic [3:0]  MSB_POS  = 4'hF;

  // Reset values.
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // Cycles from enable to the first buffer exchange.
  localparam int unsigned START_CYCLES = 3;
  localparam logic [1:0]  START_LAST   = 2'(START_CYCLES - 1);

endpackage : codec_port_pkg

// ---- rtl/link_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface link_if;
  logic sck_rise;
  logic sck_fall;
  logic fs;
  logic sdi;

  modport sync_side (
    output sck_rise,
    output sck_fall,
    output fs,
    output sdi
  );

  modport core_side (
    input sck_rise,
    input sck_fall,
    input fs,
    input sdi
  );
endinterface : link_if

`default_nettype wire

// ---- rtl/link_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module link_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Raw pins
  input  wire logic serial_clock,
  input  wire logic frame_sync,
  input  wire logic serial_in,
  // Toward the core
  link_if.sync_side lk
);

  typedef struct packed {
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic fs_s1;
    logic fs_s2;
    logic sdi_s1;
    logic sdi_s2;
  } sync_s;

  sync_s r_reg;
  sync_s r_next;

  always_comb begin
    r_next        = r_reg;
    r_next.sck_s1 = serial_clock;
    r_next.sck_s2 = r_reg.sck_s1;
    r_next.sck_d  = r_reg.sck_s2;
    r_next.fs_s1  = frame_sync;
    r_next.fs_s2  = r_reg.fs_s1;
    r_next.sdi_s1 = serial_in;
    r_next.sdi_s2 = r_reg.sdi_s1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Edges are found only on second-stage samples.
  assign lk.sck_rise = r_reg.sck_s2 & ~r_reg.sck_d;
  assign lk.sck_fall = ~r_reg.sck_s2 & r_reg.sck_d;
  assign lk.fs       = r_reg.fs_s2;
  assign lk.sdi      = r_reg.sdi_s2;

endmodule : link_sync

`default_nettype wire

// ---- rtl/codec_port_slot_buffer.sv ----
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

//Contract
// RULE1: Holding data is left justified; short words zero-fill or ignore low bits.
// RULE2: Four transmit and four receive holding registers are in the map.
// RULE3: Each holding location has a hidden buffer entry used by serial transfers.
// RULE4: Software treats transmit holding registers as write-only.
// RULE5: Every exchange between hidden buffers and holding registers interrupts.
// RULE6: Two-bit buffer length selects one to four words between interrupts.
// RULE7: Each shift-register to buffer transfer advances the buffer pointer.
// RULE8: At length plus one words: pointer to zero, swap buffers, interrupt.
// RULE9: One shared pointer; receive and transmit use the same location.
// RULE10: Sixteen-bit transmit slot enable, one bit per slot of word size.
// RULE11: Enabled transmit slot loads current location into shifter and advances.
// RULE12: Disabled transmit slot still advances the pointer but sends nothing; the code advances only if the slot's receive enable is set.
// RULE13: Slot enables beyond the configured frame length have no effect.
// RULE14: Disabled transmit slots drive zero, or float when idle mode is set.
// RULE15: Devices sharing the output line must never drive the same slot.
// RULE16: Sixteen-bit receive slot enable; each slot spans four to sixteen bits.
// RULE17: Enabled receive slot stores the word and advances; disabled only advances; the code advances a disabled one only if its transmit enable is set.
// RULE18: Received words are never packed; each is left aligned in its location.
// RULE19: Holding writes never disturb the word being shifted out.
// RULE20: Three cycles after enable: interrupt, load location 0, start shifting.
// RULE21: At that first interrupt receive holding registers read zero.
// RULE22: While disabled nothing is transmitted or received.
// RULE23: Clearing enable resets all serial, frame and buffer counters.
// RULE24: Word size field selects four to sixteen bits, coded length minus one.
// RULE25: Frame length selects one to sixteen slots, coded count minus one.
// RULE26: Each exchange interrupt is a single-cycle pulse on the system clock.
module codec_port_slot_buffer (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Serial link pins
  input  wire logic        serial_clock,
  input  wire logic        frame_sync,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_oe,
  // Interrupt request
  output logic             irq
);

  typedef struct packed {
    logic                   en;
    logic                   idle_mode;
    logic [1:0]             blen;
    logic [3:0]             fslots;
    logic [3:0]             ws;
    logic [15:0]            tx_slot;
    logic [15:0]            rx_slot;
    logic [3:0][15:0]       tx_hold;
    logic [3:0][15:0]       tx_buf;
    logic [3:0][15:0]       rx_buf;
    logic [3:0][15:0]       rx_hold;
    logic [1:0]             start_cnt;
    logic                   started;
    logic                   active;
    logic [3:0]             slot;
    logic [3:0]             bitc;
    logic [1:0]             ptr;
    logic [1:0]             count;
    logic [15:0]            tx_word;
    logic [15:0]            rx_word;
    logic                   sdo;
    logic                   sdo_oe;
    logic                   irq;
    logic [15:0]            rdata;
  } state_s;

  state_s r_reg;
  state_s r_next;

  link_if lk ();

  link_sync u_sync (
    .mclk         (mclk),
    .rst          (rst),
    .serial_clock (serial_clock),
    .frame_sync   (frame_sync),
    .serial_in    (serial_in),
    .lk           (lk.sync_side)
  );

  // Which hold group an address falls in: 1 transmit, 2 receive, 0 neither.
  function automatic logic [1:0] hold_group(input logic [3:0] a);
    if ((a & 4'hC) == codec_port_pkg::ADDR_TX_HOLD0) begin
      return 2'h1;
    end else if ((a & 4'hC) == codec_port_pkg::ADDR_RX_HOLD0) begin
      return 2'h2;
    end
    return 2'h0;
  endfunction : hold_group

  // Word sizes below four bits are treated as four.
  function automatic logic [3:0] eff_ws(input logic [3:0] ws);
    return (ws < codec_port_pkg::WS_MIN) ? codec_port_pkg::WS_MIN : ws;
  endfunction : eff_ws

  always_comb begin
    logic       exchange;
    logic       start_slot;
    logic [3:0] ws;
    r_next     = r_reg;
    exchange   = 1'b0;
    start_slot = 1'b0;
    ws         = eff_ws(r_reg.ws);
    r_next.irq   = 1'b0;
    r_next.rdata = codec_port_pkg::RESET_WORD;

    // Register writes; hold writes only touch the visible copy.
    if (reg_wr) begin
      case (reg_addr)
        codec_port_pkg::ADDR_CTRL1: begin
          r_next.en = reg_wdata[codec_port_pkg::BIT_PORT_ENABLE];
          r_next.idle_mode = reg_wdata[codec_port_pkg::BIT_IDLE_MODE];
        end
        codec_port_pkg::ADDR_CTRL2: begin
          r_next.blen   = reg_wdata[codec_port_pkg::BLEN_LSB +: 2]; // see RULE6
          r_next.fslots = reg_wdata[codec_port_pkg::FSLOTS_LSB +: 4]; // see RULE25
          r_next.ws     = reg_wdata[codec_port_pkg::WS_LSB +: 4]; // see RULE24
        end
        codec_port_pkg::ADDR_TX_SLOT: begin
          r_next.tx_slot = reg_wdata; // see RULE10
        end
        codec_port_pkg::ADDR_RX_SLOT: begin
          r_next.rx_slot = reg_wdata; // see RULE16
        end
        default: begin
          if (hold_group(reg_addr) == 2'h1) begin
            r_next.tx_hold[reg_addr[1:0]] = reg_wdata; // see RULE19
          end
        end
      endcase
    end

    // Register reads; transmit holds are write-only and read as zero.
    if (reg_rd) begin
      case (reg_addr)
        codec_port_pkg::ADDR_CTRL1: begin
          r_next.rdata[codec_port_pkg::BIT_PORT_ENABLE] = r_reg.en;
          r_next.rdata[codec_port_pkg::BIT_IDLE_MODE]   = r_reg.idle_mode;
        end
        codec_port_pkg::ADDR_CTRL2: begin
          r_next.rdata[codec_port_pkg::BLEN_LSB +: 2]   = r_reg.blen;
          r_next.rdata[codec_port_pkg::FSLOTS_LSB +: 4] = r_reg.fslots;
          r_next.rdata[codec_port_pkg::WS_LSB +: 4]     = r_reg.ws;
        end
        codec_port_pkg::ADDR_TX_SLOT: begin
          r_next.rdata = r_reg.tx_slot;
        end
        codec_port_pkg::ADDR_RX_SLOT: begin
          r_next.rdata = r_reg.rx_slot;
        end
        codec_port_pkg::ADDR_STATUS: begin
          r_next.rdata[codec_port_pkg::STAT_PTR_LSB +: 2]  = r_reg.ptr;
          r_next.rdata[codec_port_pkg::STAT_SLOT_LSB +: 4] = r_reg.slot;
          r_next.rdata[codec_port_pkg::STAT_ACTIVE]        = r_reg.active;
          r_next.rdata[codec_port_pkg::STAT_STARTED]       = r_reg.started;
        end
        default: begin
          if (hold_group(reg_addr) == 2'h2) begin
            r_next.rx_hold[reg_addr[1:0]] = r_reg.rx_hold[reg_addr[1:0]];
            r_next.rdata = r_reg.rx_hold[reg_addr[1:0]]; // see RULE2
          end
        end
      endcase
    end

    if (!r_reg.en) begin
      // Disabled: all counters and hidden buffers return to rest.
      r_next.start_cnt = 2'h0; // see RULE23
      r_next.started   = 1'b0;
      r_next.active    = 1'b0;
      r_next.slot      = 4'h0;
      r_next.bitc      = 4'h0;
      r_next.ptr       = 2'h0;
      r_next.count     = 2'h0;
      r_next.tx_buf    = '0;
      r_next.rx_buf    = '0; // see RULE21
      r_next.tx_word   = codec_port_pkg::RESET_WORD;
      r_next.rx_word   = codec_port_pkg::RESET_WORD;
    end else if (!r_reg.started) begin
      if (r_reg.start_cnt == codec_port_pkg::START_LAST) begin
        r_next.started = 1'b1; // see RULE20
        r_next.tx_word = r_reg.tx_hold[0];
        exchange       = 1'b1;
      end else begin
        r_next.start_cnt = r_reg.start_cnt + 2'h1;
      end
    end else begin
      // Receive bits are taken on the falling serial clock edge.
      if (lk.sck_fall && r_reg.active) begin
        r_next.rx_word[codec_port_pkg::MSB_POS - r_reg.bitc] = lk.sdi; // see RULE18
      end
      if (lk.sck_rise) begin
        if (lk.fs) begin
          r_next.active = 1'b1;
          r_next.slot   = 4'h0;
          r_next.bitc   = 4'h0;
          start_slot    = 1'b1;
        end else if (r_reg.active) begin
          if (r_reg.bitc == ws) begin
            if (r_reg.tx_slot[r_reg.slot] | r_reg.rx_slot[r_reg.slot]) begin
              if (r_reg.rx_slot[r_reg.slot]) begin
                r_next.rx_buf[r_reg.ptr] = r_reg.rx_word; // see RULE17
              end
              if (r_reg.count == r_reg.blen) begin
                r_next.ptr   = 2'h0; // see RULE8
                r_next.count = 2'h0;
                exchange     = 1'b1;
              end else begin
                r_next.ptr   = r_reg.ptr + 2'h1; // see RULE7
                r_next.count = r_reg.count + 2'h1; // see RULE12
              end
            end
            if (r_reg.slot == r_reg.fslots) begin
              r_next.active = 1'b0; // see RULE13
            end else begin
              r_next.slot = r_reg.slot + 4'h1;
              r_next.bitc = 4'h0;
              start_slot  = 1'b1;
            end
          end else begin
            r_next.bitc = r_reg.bitc + 4'h1;
          end
        end
      end
    end

    if (exchange) begin
      r_next.irq     = 1'b1; // see RULE5
      r_next.rx_hold = r_next.rx_buf; // see RULE3
      r_next.tx_buf  = r_reg.tx_hold;
    end

    if (start_slot) begin
      // Same pointer serves both directions within a slot.
      r_next.tx_word = r_next.tx_buf[r_next.ptr]; // see RULE9
      r_next.rx_word = codec_port_pkg::RESET_WORD; // see RULE1
    end

    // Output stage; bits past the word size are never sent.
    if (r_next.en && r_next.started && r_next.active
        && r_next.tx_slot[r_next.slot]) begin
      r_next.sdo    = r_next.tx_word[codec_port_pkg::MSB_POS - r_next.bitc]; // see RULE11
      r_next.sdo_oe = 1'b1;
    end else begin
      r_next.sdo    = 1'b0; // see RULE14
      r_next.sdo_oe = r_next.en && !r_next.idle_mode; // see RULE22
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata     = r_reg.rdata;
  assign serial_out    = r_reg.sdo;
  assign serial_out_oe = r_reg.sdo_oe;
  assign irq           = r_reg.irq; // see RULE26

endmodule : codec_port_slot_buffer

`default_nettype wire

// ---- verif/codec_port_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module codec_port_sva (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Serial output and interrupt
  input wire logic        serial_out,
  input wire logic        serial_out_oe,
  input wire logic        irq
);
  logic        en_reg;
  logic        idle_reg;
  logic        off_reg;
  logic [15:0] txen_reg;
  logic        set_ctrl;
  logic        quiet;
  assign set_ctrl = reg_wr && reg_addr == codec_port_pkg::ADDR_CTRL1;
  assign quiet = en_reg && off_reg && txen_reg == 16'h0000;
  // Shadow of the enable, idle mode and transmit slot settings.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      en_reg   <= 1'b0;
      idle_reg <= 1'b0;
      off_reg  <= 1'b1;
      txen_reg <= 16'h0000;
    end else begin
      off_reg <= txen_reg == 16'h0000;
      if (set_ctrl) begin
        en_reg   <= reg_wdata[codec_port_pkg::BIT_PORT_ENABLE];
        idle_reg <= reg_wdata[codec_port_pkg::BIT_IDLE_MODE];
      end
      if (reg_wr && reg_addr == codec_port_pkg::ADDR_TX_SLOT) begin
        txen_reg <= reg_wdata;
      end
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_irq_one_cycle: assert property (irq |=> !irq)
    else $error("irq held longer than one cycle");
  a_irq_needs_enable: assert property (irq |-> en_reg)
    else $error("irq while port disabled");
  a_start_irq_delay: assert property (
    set_ctrl && reg_wdata[15] && !en_reg |=> !irq ##1 !irq ##[1:2] irq)
    else $error("start interrupt not three cycles after enable");
  a_disabled_silent: assert property (
    !en_reg && !$past(en_reg) |-> !irq && !serial_out)
    else $error("activity while disabled");
  a_tx_off_zero: assert property (quiet |-> !serial_out)
    else $error("data sent with no transmit slot enabled");
  a_idle_float: assert property (
    quiet && idle_reg && $past(idle_reg) |-> !serial_out_oe)
    else $error("output driven in disabled slot with idle mode set");
  a_tx_hold_reads: assert property (
    reg_rd && reg_addr[3:2] == 2'b01 |=> reg_rdata == 16'h0000)
    else $error("transmit holding register read not zero");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr > codec_port_pkg::ADDR_STATUS |=> reg_rdata == 0)
    else $error("unmapped address read not zero");
endmodule : codec_port_sva
bind codec_port_slot_buffer codec_port_sva u_sva (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe), .irq(irq));
`default_nettype wire

// ---- verif/codec_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
module codec_partner (
  // Link toward the port
  output logic      serial_clock,
  output logic      frame_sync,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  logic [15:0] cap;
  logic        drove;
  initial begin
    serial_clock = 1'b0;
    frame_sync = 1'b0;
    serial_in = 1'b0;
  end
  // One-slot frame; the bit clock stands still outside it.
  task automatic frame(input logic [15:0] w, input int bits);
    cap = 16'h0000;
    drove = 1'b0;
    #1;
    for (int s = 0; s <= bits; s++) begin
      serial_clock = 1'b1;
      frame_sync = (s == 0);
      serial_in = w[15 - (s % bits)];
      #24;
      serial_clock = 1'b0;
      if (s < bits) begin
        cap[15 - s] = serial_out;
        drove = drove | serial_out_oe;
      end
      #24;
    end
    serial_in = !serial_in;
  endtask : frame
endmodule : codec_partner
`default_nettype wire

// ---- verif/codec_port_slot_buffer_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module codec_port_slot_buffer_tb;
  typedef struct packed {logic [3:0] a; logic [15:0] w; logic [15:0] e;} row_s;
  logic        mclk;
  logic        rst;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        serial_clock;
  logic        frame_sync;
  logic        serial_in;
  logic        serial_out;
  logic        serial_out_oe;
  logic        irq;
  logic [15:0] n_irq;
  logic [15:0] base;
  logic [15:0] v;
  int          n_mismatch;
  int          n_compared;
  int          cycles;
  row_s        rows [5];
  codec_port_slot_buffer u_codec_port_slot_buffer (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_clock(serial_clock), .frame_sync(frame_sync),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .irq(irq));
  codec_partner u_codec_partner (
    .serial_clock(serial_clock), .frame_sync(frame_sync),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (irq === 1'b1) n_irq++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge mclk);
  endtask : rd
  task automatic run(input logic [15:0] w);
    u_codec_partner.frame(w, 8);
    repeat (8) @(posedge mclk);
    #1;
  endtask : run
  initial begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_irq = 16'h0000;
    rows = '{{codec_port_pkg::ADDR_TX_SLOT, 16'hA5C3, 16'hA5C3},
             {codec_port_pkg::ADDR_RX_SLOT, 16'h5A3C, 16'h5A3C},
             {codec_port_pkg::ADDR_CTRL2, 16'h0DE7, 16'h0DE7},
             {4'h5, 16'h1234, 16'h0000},
             {4'hD, 16'hFFFF, 16'h0000}};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (rows[i]) begin
      rd(rows[i].a, v);
      check(v, 16'h0000);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, v);
      check(v, rows[i].e);
    end
    $display("Register table test done");
    wr(codec_port_pkg::ADDR_CTRL2, 16'h0407);
    wr(codec_port_pkg::ADDR_TX_SLOT, 16'h0001);
    wr(codec_port_pkg::ADDR_RX_SLOT, 16'h0001);
    wr(codec_port_pkg::ADDR_TX_HOLD0, 16'hA50F);
    wr(codec_port_pkg::ADDR_TX_HOLD0 + 4'h1, 16'h3C00);
    base = n_irq;
    wr(codec_port_pkg::ADDR_CTRL1, 16'h8000);
    repeat (4) @(posedge mclk);
    #1 check(n_irq, base + 16'h0001);
    rd(codec_port_pkg::ADDR_RX_HOLD0, v);
    check(v, 16'h0000);
    wr(codec_port_pkg::ADDR_TX_HOLD0, 16'hFF00);
    run(16'h96FF);
    check(u_codec_partner.cap, 16'hA500);
    check({15'h0000, u_codec_partner.drove}, 16'h0001);
    check(n_irq, base + 16'h0001);
    run(16'h69AB);
    check(u_codec_partner.cap, 16'h3C00);
    check(n_irq, base + 16'h0002);
    rd(codec_port_pkg::ADDR_RX_HOLD0, v);
    check(v, 16'h9600);
    rd(codec_port_pkg::ADDR_RX_HOLD0 + 4'h1, v);
    check(v, 16'h6900);
    run(16'h0000);
    check(u_codec_partner.cap, 16'hFF00);
    $display("Buffer exchange test done");
    wr(codec_port_pkg::ADDR_CTRL1, 16'h0000);
    base = n_irq;
    run(16'hFFFF);
    check(u_codec_partner.cap, 16'h0000);
    check(n_irq, base);
    $display("Disable test done");
    wr(codec_port_pkg::ADDR_CTRL2, 16'h0007);
    wr(codec_port_pkg::ADDR_TX_SLOT, 16'hFFFE);
    wr(codec_port_pkg::ADDR_CTRL1, 16'h8040);
    repeat (4) @(posedge mclk);
    base = n_irq;
    run(16'hC3FF);
    check({15'h0000, u_codec_partner.drove}, 16'h0000);
    check(n_irq, base + 16'h0001);
    rd(codec_port_pkg::ADDR_RX_HOLD0, v);
    check(v, 16'hC300);
    $display("Idle mode test done");
    wr(codec_port_pkg::ADDR_TX_SLOT, 16'h0000);
    base = n_irq;
    run(16'hF0FF);
    check(u_codec_partner.cap, 16'h0000);
    check({15'h0000, u_codec_partner.drove}, 16'h0000);
    check(n_irq, base + 16'h0001);
    rd(codec_port_pkg::ADDR_RX_HOLD0, v);
    check(v, 16'hF000);
    $display("No transmit slot test done");
    conclude();
  end
endmodule : codec_port_slot_buffer_tb
`default_nettype wire
